// ===== design/adcsc_pkg.sv
// constants and types for the converter status and control register block
//------------------------------------------------------------------------------
// How it works
// - ready flag bit 31 set only when band gap and reference both ready
// - ready flag reads zero whenever converter enable is clear
// - fault flag bit 30 set on reference fault while enabled
// - fault flag cleared by hardware when disabled and band gap and reference both ready
// - scan done flag bit 29 set when all selected scan inputs finish
// - reading the top byte of control two clears the scan done flag
// - capacitor select bits 28-26 give code times 2.5 pF divider capacitance
// - sample time bits 25-16 give value plus two shared clock periods
// - shared conversion clock derived from divider bits 6:0
// - ready interrupt enable bit 15 gates interrupt on ready flag rising
// - result port is read-only 32 bits, zero after reset
// - alternate input results still land in the primary input data register
//------------------------------------------------------------------------------
package adcsc_pkg;

  // ---------------------------------------------------------------------------
  // register byte offsets (low 16 bits of the address)
  // ---------------------------------------------------------------------------
  localparam logic [15:0] OFF_EARLY_IRQ_EN_HI = 16'hb0f4;
  localparam logic [15:0] OFF_EARLY_RDY_LO    = 16'hb0f8;
  localparam logic [15:0] OFF_EARLY_RDY_HI    = 16'hb0fc;
  localparam logic [15:0] OFF_ANALOG_WAKE     = 16'hb100;
  localparam logic [15:0] OFF_CORE0_CAL       = 16'hb180;
  localparam logic [15:0] OFF_CORE1_CAL       = 16'hb184;
  localparam logic [15:0] OFF_CTRL_TWO        = 16'hb200;
  localparam logic [15:0] OFF_RESULT_FIFO     = 16'hb0bc;
  localparam logic [15:0] OFF_CTRL_ONE        = 16'hb204;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int BIT_REF_READY       = 31;
  localparam int BIT_REF_FAULT       = 30;
  localparam int BIT_SCAN_DONE       = 29;
  localparam int BIT_READY_IEN       = 15;
  localparam int BIT_FAULT_IEN       = 14;
  localparam int BIT_SCAN_IEN        = 13;
  localparam int BIT_CONV_ENABLE     = 15;
  localparam int LSB_CAP_SEL         = 26;
  localparam int LSB_SAMPLE_TIME     = 16;
  localparam int LSB_DIVIDER         = 0;
  localparam int EARLY_HI_BITS       = 13;
  localparam int WAKE_CNT_LSB        = 24;
  localparam int WAKE_ENABLE_LSB     = 16;
  localparam int WAKE_READY_LSB      = 8;

  // writable masks and reset values
  localparam logic [31:0] MASK_CTRL_TWO    = 32'h1fffefff & ~32'h00000080;
  localparam logic [31:0] MASK_ANALOG_WAKE = 32'h0f9f009f;
  localparam logic [31:0] MASK_CTRL_ONE    = 32'h00008000;
  localparam logic [31:0] RST_ZERO         = 32'h00000000;
  localparam logic [6:0]  SAMPLE_BASE      = 7'h02;
  localparam logic [9:0]  SAMPLE_EXTRA     = 10'h002;

  // ---------------------------------------------------------------------------
  // carriers to and from the analog side
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] capSelect;
    logic [9:0] sampleTime;
    logic [6:0] clockDivider;
  } adcsc_shared_cfg_t;

  typedef struct packed {
    logic bandGapReady;
    logic refReady;
    logic refFault;
    logic scanDone;
  } adcsc_analog_stat_t;

endpackage : adcsc_pkg

// ===== design/adcsc_regs.sv
// register block for converter status, control two, calibration and result port
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
module adcsc_regs (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [15:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire adcsc_pkg::adcsc_analog_stat_t analogStat,
  input  wire logic [44:0]                   earlyReadyIn,
  input  wire logic [7:0]                    wakeReadyIn,
  input  wire logic                          resultValid,
  input  wire logic [31:0]                   resultData,
  output logic                               resultPop,
  output adcsc_pkg::adcsc_shared_cfg_t       sharedCfg,
  output logic                               sharedClockTick,
  output logic                               converterEnable,
  output logic                               irqOut,
  output logic [31:0]                        core0Cal,
  output logic [31:0]                        core1Cal,
  output logic [44:32]                       earlyIrqEnableHigh,
  output logic [31:0]                        analogWake
);

  // ---------------------------------------------------------------------------
  // input synchronisers (analog status comes from another domain)
  // ---------------------------------------------------------------------------
  logic [3:0]  statMeta_q, statSync_q;
  logic [44:0] earlyMeta_q, earlySync_q;
  logic [7:0]  wakeMeta_q, wakeSync_q;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      statMeta_q  <= '0;
      statSync_q  <= '0;
      earlyMeta_q <= '0;
      earlySync_q <= '0;
      wakeMeta_q  <= '0;
      wakeSync_q  <= '0;
    end
    else
    begin
      statMeta_q  <= analogStat;
      statSync_q  <= statMeta_q;
      earlyMeta_q <= earlyReadyIn;
      earlySync_q <= earlyMeta_q;
      wakeMeta_q  <= wakeReadyIn;
      wakeSync_q  <= wakeMeta_q;
    end

  logic bandGapOk, refOk, faultEvt, scanEvt;
  assign bandGapOk = statSync_q[3];
  assign refOk     = statSync_q[2];
  assign faultEvt  = statSync_q[1];
  assign scanEvt   = statSync_q[0];

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  logic access, wrEn, rdEn;
  assign access = psel & penable;
  // writes land only at the edge where the answer is sampled
  assign wrEn   = access & pwrite & pready;
  assign rdEn   = access & ~pwrite;

  logic hitEarlyHi, hitEarlyLo, hitEarlyRdyHi, hitWake, hitCal0, hitCal1;
  logic hitCtrl2, hitFifo, hitCtrl1, hitAny;
  assign hitEarlyHi    = paddr == adcsc_pkg::OFF_EARLY_IRQ_EN_HI;
  assign hitEarlyLo    = paddr == adcsc_pkg::OFF_EARLY_RDY_LO;
  assign hitEarlyRdyHi = paddr == adcsc_pkg::OFF_EARLY_RDY_HI;
  assign hitWake       = paddr == adcsc_pkg::OFF_ANALOG_WAKE;
  assign hitCal0       = paddr == adcsc_pkg::OFF_CORE0_CAL;
  assign hitCal1       = paddr == adcsc_pkg::OFF_CORE1_CAL;
  assign hitCtrl2      = paddr == adcsc_pkg::OFF_CTRL_TWO;
  assign hitFifo       = paddr == adcsc_pkg::OFF_RESULT_FIFO;
  assign hitCtrl1      = paddr == adcsc_pkg::OFF_CTRL_ONE;
  assign hitAny = hitEarlyHi | hitEarlyLo | hitEarlyRdyHi | hitWake | hitCal0 | hitCal1
                | hitCtrl2 | hitFifo | hitCtrl1;

  // ---------------------------------------------------------------------------
  // software-written registers
  // ---------------------------------------------------------------------------
  logic [31:0] ctrl2_q, ctrl1_q, cal0_q, cal1_q, wake_q;
  logic [12:0] earlyEn_q;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      ctrl2_q <= adcsc_pkg::RST_ZERO;
    else if (wrEn && hitCtrl2)
      ctrl2_q <= pwdata & adcsc_pkg::MASK_CTRL_TWO;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      ctrl1_q <= adcsc_pkg::RST_ZERO;
    else if (wrEn && hitCtrl1)
      ctrl1_q <= pwdata & adcsc_pkg::MASK_CTRL_ONE;

  // calibration words are plain storage; software fills them before enabling
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      cal0_q <= adcsc_pkg::RST_ZERO;
      cal1_q <= adcsc_pkg::RST_ZERO;
    end
    else
    begin
      if (wrEn && hitCal0)
        cal0_q <= pwdata;
      if (wrEn && hitCal1)
        cal1_q <= pwdata;
    end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      earlyEn_q <= '0;
    else if (wrEn && hitEarlyHi)
      earlyEn_q <= pwdata[adcsc_pkg::EARLY_HI_BITS-1:0];

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      wake_q <= adcsc_pkg::RST_ZERO;
    else if (wrEn && hitWake)
      wake_q <= pwdata & adcsc_pkg::MASK_ANALOG_WAKE;

  logic convOn;
  assign convOn = ctrl1_q[adcsc_pkg::BIT_CONV_ENABLE];

  // ---------------------------------------------------------------------------
  // hardware status flags
  // ---------------------------------------------------------------------------
  logic readyFlag_q, faultFlag_q, scanFlag_q, readyPrev_q;
  logic readTop;
  assign readTop = rdEn && hitCtrl2 && pready;

  // ready only with both references good, forced low while disabled
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      readyFlag_q <= 1'b0;
    else
      readyFlag_q <= convOn & bandGapOk & refOk;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      faultFlag_q <= 1'b0;
    else if (convOn && faultEvt)
      faultFlag_q <= 1'b1;
    else if (!convOn && bandGapOk && refOk)
      faultFlag_q <= 1'b0;

  // set wins over the read-clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      scanFlag_q <= 1'b0;
    else if (scanEvt)
      scanFlag_q <= 1'b1;
    else if (readTop)
      scanFlag_q <= 1'b0;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      readyPrev_q <= 1'b0;
    else
      readyPrev_q <= readyFlag_q;

  // ---------------------------------------------------------------------------
  // interrupt output
  // ---------------------------------------------------------------------------
  logic scanPrev_q, faultPrev_q;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      scanPrev_q  <= 1'b0;
      faultPrev_q <= 1'b0;
    end
    else
    begin
      scanPrev_q  <= scanFlag_q;
      faultPrev_q <= faultFlag_q;
    end

  // one-cycle pulse on each enabled flag rise
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      irqOut <= 1'b0;
    else
      irqOut <= (ctrl2_q[adcsc_pkg::BIT_READY_IEN] & readyFlag_q & ~readyPrev_q)
              | (ctrl2_q[adcsc_pkg::BIT_FAULT_IEN] & faultFlag_q & ~faultPrev_q)
              | (ctrl2_q[adcsc_pkg::BIT_SCAN_IEN] & scanFlag_q & ~scanPrev_q);

  // ---------------------------------------------------------------------------
  // shared converter clock divider
  // ---------------------------------------------------------------------------
  logic [6:0] divCnt_q;
  logic [7:0] divTarget;
  // zero divider code ticks every cycle; each code step grows the period by one
  assign divTarget = {ctrl2_q[adcsc_pkg::LSB_DIVIDER +: 7], 1'b0} + 8'h01;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      divCnt_q <= '0;
    else if ({1'b0, divCnt_q} >= divTarget[7:1] || !convOn)
      divCnt_q <= '0;
    else
      divCnt_q <= divCnt_q + 7'h01;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      sharedClockTick <= 1'b0;
    else
      sharedClockTick <= convOn && ({1'b0, divCnt_q} >= divTarget[7:1]);

  // sample time and cap select pass to the analog side as coded; the core adds
  // two clock periods to the sample count
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      sharedCfg <= '0;
    else
    begin
      sharedCfg.capSelect    <= ctrl2_q[adcsc_pkg::LSB_CAP_SEL +: 3];
      sharedCfg.sampleTime   <= ctrl2_q[adcsc_pkg::LSB_SAMPLE_TIME +: 10];
      sharedCfg.clockDivider <= ctrl2_q[adcsc_pkg::LSB_DIVIDER +: 7];
    end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      converterEnable    <= 1'b0;
      core0Cal           <= '0;
      core1Cal           <= '0;
      earlyIrqEnableHigh <= '0;
      analogWake         <= '0;
    end
    else
    begin
      converterEnable    <= convOn;
      core0Cal           <= cal0_q;
      core1Cal           <= cal1_q;
      earlyIrqEnableHigh <= earlyEn_q;
      analogWake         <= wake_q;
    end

  // ---------------------------------------------------------------------------
  // result port: holds last word delivered with resultValid in a cycle without resultPop; zero after reset
  // ---------------------------------------------------------------------------
  logic [31:0] result_q;
  // alternate-input results arrive on the primary channel's stream unchanged
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      result_q <= adcsc_pkg::RST_ZERO;
    else if (resultValid && !resultPop)
      result_q <= resultData;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      resultPop <= 1'b0;
    else
      resultPop <= rdEn && hitFifo && !pready;

  // ---------------------------------------------------------------------------
  // read mux and answer, one wait state
  // ---------------------------------------------------------------------------
  logic [31:0] rdMux;
  always_comb
  begin
    rdMux = '0;
    if (hitCtrl2)
      rdMux = {readyFlag_q, faultFlag_q, scanFlag_q, ctrl2_q[28:0]};
    else if (hitCtrl1)
      rdMux = ctrl1_q;
    else if (hitCal0)
      rdMux = cal0_q;
    else if (hitCal1)
      rdMux = cal1_q;
    else if (hitEarlyHi)
      rdMux = {19'h00000, earlyEn_q};
    else if (hitEarlyLo)
      rdMux = earlySync_q[31:0];
    else if (hitEarlyRdyHi)
      rdMux = {19'h00000, earlySync_q[44:32]};
    else if (hitWake)
      rdMux = {wake_q[31:16], wakeSync_q & 8'h9f, wake_q[7:0]};
    else if (hitFifo)
      rdMux = result_q;
  end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !hitAny;
      prdata  <= (rdEn && !pready) ? rdMux : 32'h00000000;
    end

endmodule // adcsc_regs

// ===== dv/adcsc_analog_model.sv
// analog side model: reference status, event pulses, early ready bits, result words
`timescale 1ns/100ps
module adcsc_analog_model (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     bandGapOn,
  input  wire logic                     refOn,
  input  wire logic                     faultReq,
  input  wire logic                     scanReq,
  input  wire logic                     pushReq,
  input  wire logic [31:0]              pushWord,
  input  wire logic [44:0]              earlyBits,
  output adcsc_pkg::adcsc_analog_stat_t analogStat,
  output logic [44:0]                   earlyReadyIn,
  output logic [7:0]                    wakeReadyIn,
  output logic                          resultValid,
  output logic [31:0]                   resultData
);
  logic [2:0]  faultCntQ;
  logic [2:0]  scanCntQ;
  logic [31:0] lastQ;

  // events stretched so the two-stage sync cannot miss them
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) faultCntQ <= 3'h0;
    else if (faultReq) faultCntQ <= 3'h4;
    else if (faultCntQ != 3'h0) faultCntQ <= faultCntQ - 3'h1;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst) scanCntQ <= 3'h0;
    else if (scanReq) scanCntQ <= 3'h4;
    else if (scanCntQ != 3'h0) scanCntQ <= scanCntQ - 3'h1;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst) lastQ <= 32'h0;
    else if (pushReq) lastQ <= pushWord;

  assign analogStat = '{bandGapOn, refOn, faultCntQ != 3'h0, scanCntQ != 3'h0};
  assign earlyReadyIn = earlyBits;
  assign wakeReadyIn = 8'h00;
  assign resultValid = pushReq;
  // idle word is the inverse of the last one, never a stale copy
  assign resultData = pushReq ? pushWord : ~lastQ;
endmodule // adcsc_analog_model

// ===== dv/adcsc_regs_sva.sv
// checker for the converter status and control register block
`timescale 1ns/100ps
module adcsc_regs_sva (
  input wire logic                         ref_clk,
  input wire logic                         rst,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [15:0]                  paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         resultPop,
  input wire adcsc_pkg::adcsc_shared_cfg_t sharedCfg,
  input wire logic                         sharedClockTick,
  input wire logic                         converterEnable,
  input wire logic                         irqOut
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic       acc;
  logic [2:0] ienQ;
  assign acc = psel && penable && pready;
  // updates on the same edge as the stored enables, safe as flags rise later
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) ienQ <= 3'h0;
    else if (acc && pwrite && paddr == adcsc_pkg::OFF_CTRL_TWO) ienQ <= pwdata[15:13];

  sequence s_take; psel && penable && !pready; endsequence
  sequence s_done; pready ##1 !pready; endsequence
  sequence s_rd2; acc && !pwrite && paddr == adcsc_pkg::OFF_CTRL_TWO; endsequence

  a_answer_next: assert property (s_take |=> s_done) else $error("ready late or long");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("data outside answer");
  a_err_data: assert property (pready && pslverr |-> prdata == 32'h0) else $error("error with data");
  a_ready_off: assert property (s_rd2 and !converterEnable |-> !prdata[31])
    else $error("ready flag while disabled");
  a_cfg_copy: assert property (acc && pwrite && paddr == adcsc_pkg::OFF_CTRL_TWO ##1 1'b1 |=>
    sharedCfg == {$past(pwdata[28:16], 2), $past(pwdata[6:0], 2)})
    else $error("shared config not copied");
  a_irq_gated: assert property (irqOut |-> ienQ != 3'h0) else $error("irq masked");
  a_irq_pulse: assert property (irqOut |=> !irqOut) else $error("irq too long");
  a_pop_read: assert property (acc && !pwrite && paddr == adcsc_pkg::OFF_RESULT_FIFO |->
    ##[0:1] resultPop) else $error("no pop on result read");
  a_tick_enabled: assert property (sharedClockTick |-> converterEnable || $past(converterEnable))
    else $error("tick while disabled");
  a_enable_copy: assert property (acc && pwrite && paddr == adcsc_pkg::OFF_CTRL_ONE |->
    ##2 converterEnable == $past(pwdata[15], 2)) else $error("enable not copied");
endmodule // adcsc_regs_sva

bind adcsc_regs adcsc_regs_sva i_sva (.ref_clk(ref_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .resultPop(resultPop), .sharedCfg(sharedCfg),
  .sharedClockTick(sharedClockTick), .converterEnable(converterEnable), .irqOut(irqOut));

// ===== dv/testbench.sv
// testbench for the converter status and control register block
`timescale 1ns/100ps
module testbench;
  localparam logic [15:0] A_C1 = adcsc_pkg::OFF_CTRL_ONE;
  localparam logic [15:0] A_C2 = adcsc_pkg::OFF_CTRL_TWO;
  localparam logic [15:0] A_FF = adcsc_pkg::OFF_RESULT_FIFO;
  localparam logic [15:0] A_LO = adcsc_pkg::OFF_EARLY_RDY_LO;
  localparam logic [15:0] A_EH = adcsc_pkg::OFF_EARLY_IRQ_EN_HI;
  localparam logic [15:0] OFFS [8] = '{A_EH, A_LO, adcsc_pkg::OFF_EARLY_RDY_HI,
    adcsc_pkg::OFF_ANALOG_WAKE, adcsc_pkg::OFF_CORE0_CAL, adcsc_pkg::OFF_CORE1_CAL, A_C2, A_FF};
  // factory words: arbitrary values
  localparam logic [31:0] CAL0 = 32'h5a3c0f01;
  localparam logic [31:0] CAL1 = 32'h0e1d2c3b;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic bgOn = 1'b0, rfOn = 1'b0, fltReq = 1'b0, scnReq = 1'b0, push = 1'b0;
  logic pready, pslverr, resultValid, resultPop, tick, cEn, irqOut, err;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, pushW = 32'h0, prdata, rdv, c0, c1, resultData, wake;
  logic [44:0] early = 45'h0, earlyIn;
  logic [7:0] wakeIn;
  logic [44:32] eIrqHi;
  adcsc_pkg::adcsc_analog_stat_t stat;
  adcsc_pkg::adcsc_shared_cfg_t cfg;
  int n_mismatch = 0, n_compared = 0, cyc = 0, nIrq = 0, nPop = 0, nTick = 0, t0;

  adcsc_regs i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .analogStat(stat), .earlyReadyIn(earlyIn), .wakeReadyIn(wakeIn),
    .resultValid(resultValid), .resultData(resultData), .resultPop(resultPop),
    .sharedCfg(cfg), .sharedClockTick(tick), .converterEnable(cEn), .irqOut(irqOut),
    .core0Cal(c0), .core1Cal(c1), .earlyIrqEnableHigh(eIrqHi), .analogWake(wake));
  adcsc_analog_model i_model (.ref_clk(ref_clk), .rst(rst), .bandGapOn(bgOn), .refOn(rfOn),
    .faultReq(fltReq), .scanReq(scnReq), .pushReq(push), .pushWord(pushW),
    .earlyBits(early), .analogStat(stat), .earlyReadyIn(earlyIn), .wakeReadyIn(wakeIn),
    .resultValid(resultValid), .resultData(resultData));

  always #5 ref_clk = ~ref_clk;

  // ----------------------------------------
  // monitors and hang guard
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    cyc++;
    if (irqOut === 1'b1) nIrq++;
    if (resultPop === 1'b1) nPop++;
    if (tick === 1'b1) nTick++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; released only after pready is sampled
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) n_mismatch++;
  endtask

  task automatic rc(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rdv & m, e);
  endtask

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (OFFS[i]) rc(OFFS[i], 32'hffffffff, 32'h0);
    apb(1'b1, 16'hb0c0, 32'hffffffff);
    apb(1'b0, 16'hb0c0, 32'h0);
    chk("unmapped", {err, rdv[30:0]}, 32'h80000000);
    apb(1'b1, A_FF, 32'hffffffff);
    apb(1'b1, A_LO, 32'hffffffff);
    rc(A_FF, 32'hffffffff, 32'h0);
    rc(A_LO, 32'hffffffff, 32'h0);
    apb(1'b1, A_EH, 32'hffffffff);
    rc(A_EH, 32'hffffffff, 32'h00001fff);
    chk("early enables", {19'h0, eIrqHi}, 32'h00001fff);
    apb(1'b1, A_EH, 32'h0);
    early <= 45'habc12345678;
    repeat (6) @(posedge ref_clk);
    rc(A_LO, 32'hffffffff, 32'h12345678);
    rc(adcsc_pkg::OFF_EARLY_RDY_HI, 32'hffffffff, 32'h00000abc);
    apb(1'b1, adcsc_pkg::OFF_CORE0_CAL, CAL0);
    apb(1'b1, adcsc_pkg::OFF_CORE1_CAL, CAL1);
    rc(adcsc_pkg::OFF_CORE1_CAL, 32'hffffffff, CAL1);
    chk("cal0", c0, CAL0);
    apb(1'b1, A_C2, 32'hffffffff);
    rc(A_C2, 32'hffffffff, adcsc_pkg::MASK_CTRL_TWO);
    chk("cfg", {12'h0, cfg}, 32'h000fffff);
    for (int n = 0; n < 8; n++)
    begin
      apb(1'b1, A_C2, n << 26);
      repeat (2) @(posedge ref_clk);
      chk("cap", {12'h0, cfg}, {12'h0, n[2:0], 17'h0});
    end
    apb(1'b1, A_C2, 32'h00008003);
    apb(1'b1, A_C1, 32'h00008000);
    repeat (2) @(posedge ref_clk);
    chk("enable", {31'h0, cEn}, 32'h1);
    t0 = nTick;
    repeat (40) @(posedge ref_clk);
    chk("ticks", nTick - t0, 32'd10);
    bgOn <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rc(A_C2, 32'h80000000, 32'h0);
    rfOn <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rc(A_C2, 32'h80000000, 32'h80000000);
    chk("irq", nIrq, 32'd1);
    t0 = nPop;
    pushW <= 32'hc0de1234;
    push <= 1'b1;
    @(posedge ref_clk);
    push <= 1'b0;
    rc(A_FF, 32'hffffffff, 32'hc0de1234);
    @(posedge ref_clk);
    chk("pop", nPop - t0, 32'd1);
    apb(1'b1, A_C2, 32'h0000e003);
    fltReq <= 1'b1;
    @(posedge ref_clk);
    fltReq <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rc(A_C2, 32'h40000000, 32'h40000000);
    scnReq <= 1'b1;
    @(posedge ref_clk);
    scnReq <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rc(A_C2, 32'h20000000, 32'h20000000);
    rc(A_C2, 32'h20000000, 32'h0);
    chk("irq", nIrq, 32'd3);
    apb(1'b1, A_C1, 32'h0);
    repeat (6) @(posedge ref_clk);
    rc(A_C2, 32'he0000000, 32'h0);
    apb(1'b1, A_C1, 32'h00008000);
    repeat (10) @(posedge ref_clk);
    rc(A_C2, 32'hc0000000, 32'h80000000);
    chk("irq", nIrq, 32'd4);
    apb(1'b1, A_C2, 32'h00000003);
    apb(1'b1, A_C1, 32'h0);
    apb(1'b1, A_C1, 32'h00008000);
    repeat (10) @(posedge ref_clk);
    rc(A_C2, 32'h80000000, 32'h80000000);
    chk("irq", nIrq, 32'd4);
    stop_test();
  end
endmodule // testbench
